// ---- inc/qenc_pkg.sv ----
// Purpose: Shared constants for the quadrature encoder counter bank.
// Assumes: One system clock at 100 MHz.
// Notes:   Timing figures are held in their own units and converted here.
package qenc_pkg;

	// ------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------
	localparam int unsigned CHAN_COUNT   = 4;
	localparam int unsigned CHAN_COMMUT  = 3;
	localparam int unsigned POS_WIDTH    = 24;
	localparam logic [23:0] POS_RESET    = 24'h000000;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned SERVO_MIN_NS   = 884000;
	localparam int unsigned SERVO_CYCLES   =
		(SERVO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_WIDTH      = 17;

	// Step decoded from one pair of samples.
	typedef enum logic [1:0] {STEP_NONE, STEP_UP, STEP_DOWN, STEP_ERR}
		step_t;

endpackage : qenc_pkg

// ---- hw/qenc_decoder.sv ----
// Purpose: One quadrature channel: edge decode and 24-bit accumulation.
// Assumes: Phase inputs are squared, synchronous to clk_sys.
// Notes:   Illegal double transitions are flagged and not counted.
`timescale 1ns/1ps
module qenc_decoder
	import qenc_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 clk_en,
	// Encoder phases
	input  wire logic                 phase_a,
	input  wire logic                 phase_b,
	// Result
	output logic [POS_WIDTH-1:0]      position,
	output logic                      step_error
);

	logic [1:0]            prev_reg;
	logic [1:0]            prev_next;
	logic [POS_WIDTH-1:0]  pos_reg;
	logic [POS_WIDTH-1:0]  pos_next;
	logic                  err_reg;
	logic                  err_next;
	step_t                 step;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// Every change of either phase is one count, giving fourfold
	// resolution; the direction follows which phase leads.
	always_comb
	begin
		logic [3:0] code;
		code = {prev_reg, phase_a, phase_b};
		unique case (code)
			4'h1, 4'h7, 4'hE, 4'h8: step = STEP_UP;   // R02 R03
			4'h2, 4'hB, 4'hD, 4'h4: step = STEP_DOWN; // R02 R03
			4'h3, 4'hC, 4'h6, 4'h9: step = STEP_ERR;
			default:                step = STEP_NONE;
		endcase
	end

	always_comb
	begin
		prev_next = {phase_a, phase_b};
		pos_next  = pos_reg;
		err_next  = 1'b0;
		unique case (step)
			STEP_UP:   pos_next = pos_reg + 24'h000001;    // R04 R10
			STEP_DOWN: pos_next = pos_reg - 24'h000001;    // R04 R10
			STEP_ERR:  err_next = 1'b1;
			STEP_NONE: pos_next = pos_reg;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			prev_reg <= 2'h0;
			pos_reg  <= POS_RESET; // R10
			err_reg  <= 1'b0;
		end
		else if (clk_en)
		begin
			prev_reg <= prev_next;
			pos_reg  <= pos_next;
			err_reg  <= err_next;
		end
	end

	assign position   = pos_reg;
	assign step_error = err_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	AST_UP_ONE: assert property (@(posedge clk_sys) disable iff (!nrst) // R03
		clk_en && step == STEP_UP |=> pos_reg == $past(pos_reg) + 24'h000001)
		else $error("Up step did not add one.");
	AST_DOWN_ONE: assert property (@(posedge clk_sys) disable iff (!nrst) // R02
		clk_en && step == STEP_DOWN |=> pos_reg == $past(pos_reg) - 24'h000001)
		else $error("Down step did not subtract one.");
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst) // R04
		!clk_en || step == STEP_NONE || step == STEP_ERR |=> $stable(pos_reg))
		else $error("Position moved without a step.");
	AST_WRAP: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
		clk_en && step == STEP_UP && pos_reg == 24'hFFFFFF
		|=> pos_reg == 24'h000000)
		else $error("Counter did not wrap at the top.");

endmodule : qenc_decoder

// ---- hw/qenc_bank.sv ----
// Purpose: Bank of four quadrature encoder position counters.
// Assumes: Phase inputs squared and synchronous; reader samples freely.
// Notes:   Position outputs are registered copies of each live counter.
//
// Function
// R01: Four channels; channel three drives commutation.
// R02: Phase order sets count up or down.
// R03: Count both edges of both phases.
// R04: Accumulate into 24-bit counters, always readable.
// R05: Reader samples at each servo tick, extends to 48 bits.
// R06: Encoder phases quarter-cycle apart, squared logic.
// R07: Reader samples no faster than minimum period.
// R08: Periodic tick paces the servo reads.
// R09: Position encoders 4000 lines, commutation 1000.
// R10: Counters reset to zero, wrap two's complement.
`timescale 1ns/1ps
module qenc_bank
	import qenc_pkg::*;
#(
	parameter int unsigned SERVO_PERIOD = SERVO_CYCLES
)
(
	// Clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         nrst,
	input  wire logic                         clk_en,
	// Encoder phases, one bit per channel
	input  wire logic [CHAN_COUNT-1:0]        enc_a,
	input  wire logic [CHAN_COUNT-1:0]        enc_b,
	// Position counters
	output logic [CHAN_COUNT*POS_WIDTH-1:0]   position,
	output logic [POS_WIDTH-1:0]              commut_position,
	// Status
	output logic [CHAN_COUNT-1:0]             phase_error,
	output logic                              servo_tick
);

	logic [CHAN_COUNT*POS_WIDTH-1:0]  live;
	logic [CHAN_COUNT-1:0]            err_live;
	logic [CHAN_COUNT*POS_WIDTH-1:0]  pos_reg;
	logic [CHAN_COUNT*POS_WIDTH-1:0]  pos_next;
	logic [POS_WIDTH-1:0]             com_reg;
	logic [POS_WIDTH-1:0]             com_next;
	logic [CHAN_COUNT-1:0]            perr_reg;
	logic [CHAN_COUNT-1:0]            perr_next;
	logic [CNT_WIDTH-1:0]             tick_cnt_reg;
	logic [CNT_WIDTH-1:0]             tick_cnt_next;
	logic                             tick_reg;
	logic                             tick_next;
	logic [CNT_WIDTH-1:0]             gap_reg;
	logic [CNT_WIDTH-1:0]             gap_next;

	// ------------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------------
	for (genvar i = 0; i < CHAN_COUNT; i++)
	begin : g_chan
		qenc_decoder u_dec ( // R01
			.clk_sys    (clk_sys),
			.nrst       (nrst),
			.clk_en     (clk_en),
			.phase_a    (enc_a[i]),
			.phase_b    (enc_b[i]),
			.position   (live[i*POS_WIDTH +: POS_WIDTH]),
			.step_error (err_live[i])
		);
	end

	// ------------------------------------------------------------------
	// Output registers and servo pacing tick
	// ------------------------------------------------------------------
	// The reader sees a copy one cycle behind the counter, so a read
	// never stalls counting; the wrap lets the reader extend to wider
	// words as long as it samples often enough.
	always_comb
	begin
		pos_next  = live;                                          // R04
		com_next  = live[CHAN_COMMUT*POS_WIDTH +: POS_WIDTH];      // R01
		perr_next = perr_reg | err_live;
		tick_next = 1'b0;
		if (tick_cnt_reg == CNT_WIDTH'(SERVO_PERIOD - 1))
		begin
			tick_cnt_next = '0;
			tick_next     = 1'b1;                                  // R08
		end
		else
			tick_cnt_next = tick_cnt_reg + 1'b1;
		// Sticky phase errors clear on each tick, new errors win.
		if (tick_reg)
			perr_next = err_live;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			pos_reg      <= {CHAN_COUNT{POS_RESET}};                // R10
			com_reg      <= POS_RESET;
			perr_reg     <= '0;
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end
		else if (clk_en)
		begin
			pos_reg      <= pos_next;
			com_reg      <= com_next;
			perr_reg     <= perr_next;
			tick_cnt_reg <= tick_cnt_next;
			tick_reg     <= tick_next;
		end
	end

	assign position        = pos_reg;
	assign commut_position = com_reg;
	assign phase_error     = perr_reg;
	assign servo_tick      = tick_reg;

	// ------------------------------------------------------------------
	// Reader contract
	// ------------------------------------------------------------------
	// The counters wrap rather than saturate, so the reader widens them by
	// adding the signed difference between two samples. That only works
	// while less than half the counter range passes between two reads;
	// the servo tick paces reads far inside that limit.
	// There is no read strobe: the reader may sample on any cycle, and a
	// read can never hold up counting.

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	AST_COPY: assert property (@(posedge clk_sys) disable iff (!nrst) // R04
		clk_en |=> pos_reg == $past(live))
		else $error("Output copy lags the counters wrongly.");
	AST_COMMUT: assert property (@(posedge clk_sys) disable iff (!nrst) // R01
		com_reg == pos_reg[CHAN_COMMUT*POS_WIDTH +: POS_WIDTH])
		else $error("Commutation output differs from channel three.");
	AST_TICK_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst) // R08
		tick_reg && clk_en |=> !tick_reg)
		else $error("Servo tick longer than one cycle.");
	AST_TICK_CAUSE: assert property (@(posedge clk_sys) disable iff (!nrst) // R08
		$rose(tick_reg) |-> $past(tick_cnt_reg) == CNT_WIDTH'(SERVO_PERIOD - 1))
		else $error("Servo tick at wrong count.");

	AST_TICK_RANGE: assert property (@(posedge clk_sys) disable iff (!nrst) // R08
		tick_cnt_reg < CNT_WIDTH'(SERVO_PERIOD))
		else $error("Servo tick counter ran past its period.");

	AST_FREEZE: assert property (@(posedge clk_sys) disable iff (!nrst) // R04
		!clk_en |=> $stable(pos_reg) && $stable(com_reg)
			&& $stable(perr_reg) && $stable(tick_cnt_reg)
			&& $stable(tick_reg))
		else $error("State moved while the clock enable was low.");

	// ------------------------------------------------------------------
	// Phase error flags
	// ------------------------------------------------------------------
	// A fresh error in the tick cycle must survive the clear, or the
	// reader could miss a fault that lands exactly on its sample.
	// Flags only ever rise because a decoder reported a double step.
	AST_PERR_SET: assert property (@(posedge clk_sys) disable iff (!nrst) // R03
		clk_en |=> (perr_reg & $past(err_live)) == $past(err_live))
		else $error("A new phase error was lost.");

	AST_PERR_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst) // R03
		clk_en && tick_reg |=> perr_reg == $past(err_live))
		else $error("Phase errors did not clear on the tick.");

	AST_PERR_KEEP: assert property (@(posedge clk_sys) disable iff (!nrst) // R03
		clk_en && !tick_reg
		|=> perr_reg == ($past(perr_reg) | $past(err_live)))
		else $error("Phase errors did not stay sticky.");

	AST_PERR_SPUR: assert property (@(posedge clk_sys) disable iff (!nrst) // R03
		clk_en
		|=> (perr_reg & ~$past(perr_reg) & ~$past(err_live)) == '0)
		else $error("A phase error rose without a cause.");

	// ------------------------------------------------------------------
	// Per-channel counting
	// ------------------------------------------------------------------
	// Each decoder takes at most one step per sample, so a copy can move
	// by one count at most between two enabled cycles.
	for (genvar j = 0; j < CHAN_COUNT; j++)
	begin : g_chk
		AST_ONE_COUNT: assert property (@(posedge clk_sys) // R03
			disable iff (!nrst)
			clk_en |=> (pos_reg[j*POS_WIDTH +: POS_WIDTH]
				- $past(pos_reg[j*POS_WIDTH +: POS_WIDTH]))
				inside {24'h000000, 24'h000001, 24'hFFFFFF})
			else $error("A counter moved by more than one count.");

		AST_ERR_NO_COUNT: assert property (@(posedge clk_sys) // R02
			disable iff (!nrst)
			err_live[j] |-> live[j*POS_WIDTH +: POS_WIDTH]
				== $past(live[j*POS_WIDTH +: POS_WIDTH]))
			else $error("A double transition was counted.");
	end

	// ------------------------------------------------------------------
	// Independent tick spacing
	// ------------------------------------------------------------------
	// This count of enabled cycles shares nothing with the tick counter,
	// so a wrong period cannot hide behind the logic that it checks.
	// It exists for the check alone and drives no output.
	always_comb
	begin
		if (tick_reg)
			gap_next = CNT_WIDTH'(1);
		else
			gap_next = gap_reg + 1'b1;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			gap_reg <= '0;
		else if (clk_en)
			gap_reg <= gap_next;
	end

	AST_TICK_GAP: assert property (@(posedge clk_sys) disable iff (!nrst) // R08
		$rose(tick_reg) |-> gap_reg == CNT_WIDTH'(SERVO_PERIOD))
		else $error("Servo ticks not one period apart.");

endmodule : qenc_bank

// ---- tb/qenc_encoder_model.sv ----
// Purpose: Behavioural incremental encoder driving one phase pair.
// Assumes: Commands arrive away from the rising edge.
// Notes:   A jump moves two states at once, to provoke the error path.
`timescale 1ns/1ps
module qenc_encoder_model
(
	// Clock
	input  wire logic clk_sys,
	// Commands
	input  wire logic step_up,
	input  wire logic step_dn,
	input  wire logic jump,
	// Squared phases
	output logic      phase_a,
	output logic      phase_b
);
	logic [1:0] pos_reg = 2'h0;

	// Gray order keeps the two phases a quarter cycle apart.
	always_ff @(posedge clk_sys)
		pos_reg <= pos_reg + {jump, step_up ^ step_dn} + {step_dn, 1'b0};
	assign phase_a = pos_reg[1];
	assign phase_b = pos_reg[1] ^ pos_reg[0];
endmodule : qenc_encoder_model

// ---- tb/quadrature_encoder_counters_tb.sv ----
// Purpose: Self-checking bench for the encoder counter bank.
// Assumes: Tick period shortened to 16 cycles.
// Notes:   Expected counts are kept per channel by the bench.
`timescale 1ns/1ps
module quadrature_encoder_counters_tb
	import qenc_pkg::*;
;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
	logic        clk_sys = 1'b0;
	logic        nrst    = 1'b0;
	logic        clk_en  = 1'b1;
	logic [3:0]  up = 4'h0, dn = 4'h0, jmp = 4'h0;
	logic [3:0]  enc_a, enc_b, phase_error;
	logic [95:0] position;
	logic [23:0] commut_position, exp_pos [4];
	logic        servo_tick, seen;
	logic [23:0] rd_last = 24'h000000, rd_delta;
	logic [47:0] rd_ext = 48'h000000000000, exp_ext = 48'h000000000000;
	localparam int LINES_POS = 4000, LINES_COM = 1000;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 32'h83b5, r, k;

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	for (genvar i = 0; i < 4; i++)
	begin : g_enc
		qenc_encoder_model u_enc (.clk_sys(clk_sys), .step_up(up[i]),
			.step_dn(dn[i]), .jump(jmp[i]), .phase_a(enc_a[i]),
			.phase_b(enc_b[i]));
	end

	qenc_bank #(.SERVO_PERIOD(16)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
		.clk_en(clk_en), .enc_a(enc_a), .enc_b(enc_b), .position(position),
		.commut_position(commut_position), .phase_error(phase_error),
		.servo_tick(servo_tick));

	// Reader: widens channel 0 only at the pacing tick, never faster.
	always @(negedge clk_sys)
		if (nrst && servo_tick === 1'b1)
		begin
			rd_delta = position[23:0] - rd_last;
			rd_ext   = rd_ext + {{24{rd_delta[23]}}, rd_delta};
			rd_last  = position[23:0];
		end

	function automatic logic [23:0] nxt(input logic [23:0] e, input int c);
		return (c == 1) ? e + 24'h000001 : (c == 2) ? e - 24'h000001 : e;
	endfunction : nxt

	function automatic logic [47:0] stp(input int c);
		return (c == 1) ? 48'h000000000001
			: (c == 2) ? 48'hFFFFFFFFFFFF : 48'h000000000000;
	endfunction : stp

	task automatic check_all();
		for (int i = 0; i < 4; i++)
			`CHK("position", exp_pos[i], position[24*i +: 24])
		`CHK("commut_position", exp_pos[3], commut_position)
	endtask : check_all

	task automatic pulse(input int ch, input int c);
		@(negedge clk_sys);
		up = 4'(c == 1) << ch;
		dn = 4'(c == 2) << ch;
		jmp = 4'(c == 3) << ch;
		exp_pos[ch] = nxt(exp_pos[ch], c);
		if (ch == 0)
			exp_ext += stp(c);
		@(negedge clk_sys);
		up = 4'h0;
		dn = 4'h0;
		jmp = 4'h0;
		repeat (4) @(negedge clk_sys);
	endtask : pulse

	task automatic wait_tick(output int n);
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end while (servo_tick !== 1'b1 && n < 40);
	endtask : wait_tick

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	initial
	begin
		for (int i = 0; i < 4; i++)
			exp_pos[i] = 24'h000000;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys) nrst = 1'b1;
		repeat (2) @(negedge clk_sys);
		check_all();
		pulse(0, 2);
		`CHK("wrap down", 24'hFFFFFF, position[23:0])
		wait_tick(r);
		@(negedge clk_sys);
		`CHK("extended", 48'hFFFFFFFFFFFF, rd_ext)
		pulse(0, 1);
		`CHK("wrap up", 24'h000000, position[23:0])
		for (k = 0; k < 600; k++)
		begin
			@(negedge clk_sys);
			for (int i = 0; i < 4; i++)
			begin
				r = {$random(seed)} % 3;
				up[i] = r == 1;
				dn[i] = r == 2;
				exp_pos[i] = nxt(exp_pos[i], r);
				if (i == 0)
					exp_ext += stp(r);
			end
		end
		pulse(0, 0);
		check_all();
		// One revolution of each kind of encoder, counted fourfold.
		exp_pos[0] += 24'(4 * LINES_POS);
		exp_pos[3] += 24'(4 * LINES_COM);
		exp_ext += 48'(4 * LINES_POS);
		for (k = 0; k < 4 * LINES_POS; k++)
		begin
			@(negedge clk_sys);
			up = (k < 4 * LINES_COM) ? 4'h9 : 4'h1;
		end
		pulse(0, 0);
		check_all();
		clk_en = 1'b0;
		pulse(1, 1);
		`CHK("frozen", nxt(exp_pos[1], 2), position[47:24])
		clk_en = 1'b1;
		repeat (4) @(negedge clk_sys);
		check_all();
		seen = 1'b0;
		@(negedge clk_sys);
		jmp = 4'h4;
		@(negedge clk_sys);
		jmp = 4'h0;
		for (k = 0; k < 6; k++)
		begin
			@(negedge clk_sys);
			seen |= phase_error[2];
		end
		`CHK("phase_error", 1'b1, seen)
		check_all();
		wait_tick(r);
		wait_tick(r);
		`CHK("tick period", 16, r)
		wait_tick(r);
		`CHK("error cleared", 4'h0, phase_error)
		@(negedge clk_sys);
		`CHK("extended", exp_ext, rd_ext)
		wrap_up();
	end
endmodule : quadrature_encoder_counters_tb
